// ===== logic/aiss_pkg.sv
package aiss_pkg;
  // ====================================================================
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CHEN = 8'h04;
  localparam logic [7:0] REG_STCMP = 8'h08;
  localparam logic [7:0] REG_SPCMP = 8'h0C;
  localparam logic [7:0] REG_SCOUNT = 8'h10;
  localparam logic [7:0] REG_REPEAT = 8'h14;
  localparam logic [7:0] REG_CLKDIV = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_ISTAT = 8'h20;
  localparam logic [7:0] REG_IMASK = 8'h24;
  localparam logic [7:0] REG_DATA = 8'h28;
  localparam logic [7:0] REG_LEVEL = 8'h2C;
  // ====================================================================
  // reset values and sizes
  localparam logic [15:0] CHEN_RST = 16'h0001;
  localparam logic [15:0] SCOUNT_RST = 16'h0010;
  localparam logic [15:0] REPEAT_RST = 16'h0001;
  localparam logic [15:0] CLKDIV_RST = 16'h0063;
  localparam int unsigned DEPTH = 256;
  localparam logic [8:0] LVL_FULL = 9'h100;
  localparam logic [4:0] CH_NONE = 5'h10;
  localparam logic [15:0] MASK12 = 16'h0FFF;
  // ====================================================================
  // interrupt status bit positions
  localparam int unsigned IRQ_START = 0;
  localparam int unsigned IRQ_REP = 1;
  localparam int unsigned IRQ_DONE = 2;
  localparam int unsigned IRQ_CNT = 3;
  localparam int unsigned IRQ_OVF = 4;
  localparam int unsigned IRQ_CLK = 5;
  localparam int unsigned IRQ_CERR = 6;
  localparam int unsigned IRQ_N = 7;
  // ====================================================================
  // condition sources
  localparam logic [1:0] START_SW = 2'h0;
  localparam logic [1:0] START_CMP = 2'h1;
  localparam logic [1:0] START_TRIG = 2'h2;
  localparam logic [1:0] STOP_CNT = 2'h0;
  localparam logic [1:0] STOP_CMP = 2'h1;
  localparam logic [1:0] STOP_TRIG = 2'h2;
  localparam logic [1:0] STOP_SW = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM = 2'b01,
    ST_RUN = 2'b10
  } aiss_state_t;

  // go and abort are command strobes and always read back as zero
  typedef struct packed {
    logic [15:0] rsvd;
    logic [1:0] stop_dir;
    logic [1:0] start_dir;
    logic stop_fall;
    logic start_fall;
    logic [1:0] stop_src;
    logic [1:0] start_src;
    logic ext_clk;
    logic diff;
    logic res16;
    logic ring;
    logic abort;
    logic go;
  } aiss_ctrl_t;

  // compare setup: channel and level
  typedef struct packed {
    logic [11:0] rsvd;
    logic [3:0] ch;
    logic [15:0] level;
  } aiss_cmp_t;
endpackage

// ===== logic/aiss_top.sv
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module aiss_top (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // converter front end
  output logic o_conv_start,
  output logic [3:0] o_conv_ch,
  input wire logic i_conv_done,
  input wire logic [15:0] i_conv_data,
  input wire logic i_conv_err,
  // external pins
  input wire logic i_ext_sclk,
  input wire logic i_start_trig,
  input wire logic i_stop_trig,
  // status
  output logic o_irq,
  output logic o_busy
);
  import aiss_pkg::*;

  function automatic logic [4:0] first_ch(input logic [15:0] m, input logic [4:0] lo);
    first_ch = CH_NONE;
    for (int i = 15; i >= 0; i--)
    begin
      if (m[i] && (5'(i) >= lo))
        first_ch = 5'(i);
    end
  endfunction

  function automatic logic crossed(input logic [15:0] p, input logic [15:0] c, input logic [15:0] l,
                                   input logic [1:0] dir);
    crossed = (dir[0] && (p < l) && (c >= l)) || (dir[1] && (p >= l) && (c < l));
  endfunction

  // ====================================================================
  // registers
  aiss_ctrl_t ctrl_q;
  aiss_cmp_t stcmp_q, spcmp_q;
  aiss_state_t state_q;
  logic [15:0] chen_q, scount_q, repeat_q, clkdiv_q, dcnt_q, samp_q, rep_q;
  logic [15:0] prev_st_q, prev_sp_q, mem_q [DEPTH];
  logic prev_st_v_q, prev_sp_v_q, scan_q, cnt_stk_q, cnt_st_d1_q;
  logic [2:0] sy1_q, sy2_q, sy3_q;
  logic [7:0] wp_q, rp_q, rof_q;
  logic [8:0] lvl_q;
  logic [IRQ_N-1:0] ist_q, imask_q;

  // ====================================================================
  // apb decode
  wire acc = i_psel && i_penable && !o_pready;
  wire wr = acc && i_pwrite;
  wire rd = acc && !i_pwrite;
  wire a_ctrl = i_paddr == REG_CTRL;
  wire a_data = i_paddr == REG_DATA;
  wire a_ok = a_ctrl || i_paddr == REG_CHEN || i_paddr == REG_STCMP || i_paddr == REG_SPCMP
    || i_paddr == REG_SCOUNT || i_paddr == REG_REPEAT || i_paddr == REG_CLKDIV
    || i_paddr == REG_STATUS || i_paddr == REG_ISTAT || i_paddr == REG_IMASK || a_data
    || i_paddr == REG_LEVEL;
  wire go = wr && a_ctrl && i_pwdata[0] && !i_pwdata[1];
  wire abort = wr && a_ctrl && i_pwdata[1];
  // go acts on the settings written with it, not on the ones they replace
  wire aiss_ctrl_t ctrl_new = {16'h0000, i_pwdata[15:2], 2'b00};

  // ====================================================================
  // pins and sample clock
  wire sclk_rise = sy2_q[0] && !sy3_q[0];
  wire st_edge = ctrl_q.start_fall ? (!sy2_q[1] && sy3_q[1]) : (sy2_q[1] && !sy3_q[1]);
  wire sp_edge = ctrl_q.stop_fall ? (!sy2_q[2] && sy3_q[2]) : (sy2_q[2] && !sy3_q[2]);
  wire div_hit = dcnt_q >= clkdiv_q;
  wire tick = ctrl_q.ext_clk ? sclk_rise : div_hit;

  // ====================================================================
  // scan sequencing
  // differential pairs use the lower half of the inputs only
  wire [15:0] chmask = ctrl_q.diff ? {8'h00, chen_q[7:0]} : chen_q;
  wire scanning = state_q == ST_RUN || (state_q == ST_ARM && ctrl_q.start_src == START_CMP);
  wire [4:0] ch_first = first_ch(chmask, 5'h00);
  wire [4:0] ch_next = first_ch(chmask, 5'({1'b0, o_conv_ch} + 5'h01));
  wire done = i_conv_done && scan_q;
  wire scan_go = tick && scanning && !scan_q && ch_first != CH_NONE;
  wire scan_end = done && ch_next == CH_NONE;
  wire [15:0] sample = ctrl_q.res16 ? i_conv_data : (i_conv_data & MASK12);

  // ====================================================================
  // start and stop conditions
  wire st_cmp = done && {1'b0, o_conv_ch} == {1'b0, stcmp_q.ch} && prev_st_v_q
    && crossed(prev_st_q, sample, stcmp_q.level, ctrl_q.start_dir);
  wire sp_cmp = done && {1'b0, o_conv_ch} == {1'b0, spcmp_q.ch} && prev_sp_v_q
    && crossed(prev_sp_q, sample, spcmp_q.level, ctrl_q.stop_dir);
  wire start_met = state_q == ST_ARM
    && ((ctrl_q.start_src == START_CMP && st_cmp) || (ctrl_q.start_src == START_TRIG && st_edge));
  wire stop_met = state_q == ST_RUN && (
    (ctrl_q.stop_src == STOP_CNT && scan_end && samp_q + 16'h0001 >= scount_q)
    || (ctrl_q.stop_src == STOP_CMP && sp_cmp)
    || (ctrl_q.stop_src == STOP_TRIG && sp_edge));
  // software start cannot rearm, so it always ends after one pass
  wire rep_more = ctrl_q.start_src != START_SW
    && (repeat_q == 16'h0000 || rep_q + 16'h0001 < repeat_q);

  // ====================================================================
  // buffer
  wire full = lvl_q == LVL_FULL;
  wire empty = lvl_q == 9'h000;
  wire store = state_q == ST_RUN && done;
  wire ovf = store && full;
  wire push = store && (!full || ctrl_q.ring);
  wire pop = rd && a_data && !ctrl_q.ring && !empty;
  wire [8:0] scount9 = scount_q > 16'h0100 ? LVL_FULL : scount_q[8:0];
  wire cnt_st = ctrl_q.ring ? cnt_stk_q : (lvl_q >= scount9 && scount_q != 16'h0000);
  wire [7:0] rd_idx = ctrl_q.ring ? 8'(rp_q + rof_q) : rp_q;

  // ====================================================================
  // errors and events
  wire clk_err = tick && scanning && scan_q;
  wire cerr = i_conv_err && state_q != ST_IDLE;
  wire err = (ovf && !ctrl_q.ring) || clk_err || cerr;
  wire to_idle = state_q != ST_IDLE && (abort || err || (stop_met && !rep_more));
  wire [IRQ_N-1:0] ev;
  assign ev[IRQ_START] = start_met;
  assign ev[IRQ_REP] = stop_met;
  assign ev[IRQ_DONE] = to_idle;
  assign ev[IRQ_CNT] = cnt_st && !cnt_st_d1_q;
  assign ev[IRQ_OVF] = ovf;
  assign ev[IRQ_CLK] = clk_err;
  assign ev[IRQ_CERR] = cerr;
  // a new event wins over a write-one clear in the same cycle
  wire [IRQ_N-1:0] w1c = (wr && i_paddr == REG_ISTAT) ? i_pwdata[IRQ_N-1:0] : '0;
  wire [IRQ_N-1:0] ist_d = (ist_q & ~w1c) | ev;

  wire [31:0] rd_mux =
    a_ctrl ? {16'h0000, ctrl_q[15:2], 2'b00} :
    i_paddr == REG_CHEN ? {16'h0000, chen_q} :
    i_paddr == REG_STCMP ? 32'(stcmp_q) :
    i_paddr == REG_SPCMP ? 32'(spcmp_q) :
    i_paddr == REG_SCOUNT ? {16'h0000, scount_q} :
    i_paddr == REG_REPEAT ? {16'h0000, repeat_q} :
    i_paddr == REG_CLKDIV ? {16'h0000, clkdiv_q} :
    i_paddr == REG_STATUS ? {rep_q, 11'h000, empty, full, cnt_st, state_q == ST_ARM, state_q != ST_IDLE} :
    i_paddr == REG_ISTAT ? {25'h0000000, ist_q} :
    i_paddr == REG_IMASK ? {25'h0000000, imask_q} :
    a_data ? {16'h0000, empty ? 16'h0000 : mem_q[rd_idx]} :
    i_paddr == REG_LEVEL ? {samp_q, 7'h00, lvl_q} : 32'h00000000;

  // ====================================================================
  // apb slave and configuration
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      ctrl_q <= '0;
      chen_q <= CHEN_RST;
      stcmp_q <= '0;
      spcmp_q <= '0;
      scount_q <= SCOUNT_RST;
      repeat_q <= REPEAT_RST;
      clkdiv_q <= CLKDIV_RST;
      imask_q <= '0;
      ist_q <= '0;
      o_irq <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_pready <= acc;
      o_pslverr <= acc && !a_ok;
      if (rd)
        o_prdata <= rd_mux;
      if (wr && a_ctrl)
        ctrl_q <= ctrl_new;
      if (wr && i_paddr == REG_CHEN)
        chen_q <= i_pwdata[15:0];
      if (wr && i_paddr == REG_STCMP)
        stcmp_q <= {12'h000, i_pwdata[19:0]};
      if (wr && i_paddr == REG_SPCMP)
        spcmp_q <= {12'h000, i_pwdata[19:0]};
      if (wr && i_paddr == REG_SCOUNT)
        scount_q <= i_pwdata[15:0];
      if (wr && i_paddr == REG_REPEAT)
        repeat_q <= i_pwdata[15:0];
      if (wr && i_paddr == REG_CLKDIV)
        clkdiv_q <= i_pwdata[15:0];
      if (wr && i_paddr == REG_IMASK)
        imask_q <= i_pwdata[IRQ_N-1:0];
      ist_q <= ist_d;
      o_irq <= |(ist_d & imask_q);
    end
  end

  // ====================================================================
  // synchronisers and divider
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sy1_q <= 3'h0;
      sy2_q <= 3'h0;
      sy3_q <= 3'h0;
      dcnt_q <= 16'h0000;
    end
    else if (i_clk_en)
    begin
      sy1_q <= {i_stop_trig, i_start_trig, i_ext_sclk};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      dcnt_q <= (div_hit || state_q == ST_IDLE) ? 16'h0000 : dcnt_q + 16'h0001;
    end
  end

  // ====================================================================
  // sequencer
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_q <= ST_IDLE;
      samp_q <= 16'h0000;
      rep_q <= 16'h0000;
      o_busy <= 1'b0;
    end
    else if (i_clk_en)
    begin
      unique case (state_q)
        ST_IDLE:
          if (go)
          begin
            state_q <= ctrl_new.start_src == START_SW ? ST_RUN : ST_ARM;
            samp_q <= 16'h0000;
            rep_q <= 16'h0000;
          end
        ST_ARM:
          if (to_idle)
            state_q <= ST_IDLE;
          else if (start_met)
            state_q <= ST_RUN;
        ST_RUN:
          if (to_idle)
            state_q <= ST_IDLE;
          else if (stop_met)
          begin
            state_q <= ST_ARM;
            rep_q <= rep_q + 16'h0001;
            samp_q <= 16'h0000;
          end
          else if (scan_end)
            samp_q <= samp_q + 16'h0001;
        default:
          state_q <= ST_IDLE;
      endcase
      o_busy <= (state_q == ST_IDLE) ? go : !to_idle;
    end
  end

  // a stop or a fault drops the scan; a late result is then ignored
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      scan_q <= 1'b0;
      o_conv_start <= 1'b0;
      o_conv_ch <= 4'h0;
    end
    else if (i_clk_en)
    begin
      o_conv_start <= scan_go || (done && !scan_end && !to_idle && !stop_met);
      if (to_idle || stop_met || scan_end)
        scan_q <= 1'b0;
      else if (scan_go)
        scan_q <= 1'b1;
      if (scan_go)
        o_conv_ch <= ch_first[3:0];
      else if (done && !scan_end)
        o_conv_ch <= ch_next[3:0];
    end
  end

  // previous value of each compare channel, refreshed per arm
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      prev_st_q <= 16'h0000;
      prev_sp_q <= 16'h0000;
      prev_st_v_q <= 1'b0;
      prev_sp_v_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (go || stop_met)
      begin
        prev_st_v_q <= 1'b0;
        prev_sp_v_q <= 1'b0;
      end
      else if (done)
      begin
        if (o_conv_ch == stcmp_q.ch)
        begin
          prev_st_q <= sample;
          prev_st_v_q <= 1'b1;
        end
        if (o_conv_ch == spcmp_q.ch && state_q == ST_RUN)
        begin
          prev_sp_q <= sample;
          prev_sp_v_q <= 1'b1;
        end
      end
    end
  end

  // ====================================================================
  // sample memory
  always_ff @(posedge i_clk_sys)
  begin
    if (i_clk_en && push)
      mem_q[wp_q] <= sample;
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wp_q <= 8'h00;
      rp_q <= 8'h00;
      rof_q <= 8'h00;
      lvl_q <= 9'h000;
      cnt_stk_q <= 1'b0;
      cnt_st_d1_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (push)
        wp_q <= wp_q + 8'h01;
      // overwriting in ring mode drags the oldest entry along
      if (pop || (push && full))
        rp_q <= rp_q + 8'h01;
      if (push && !full && !pop)
        lvl_q <= lvl_q + 9'h001;
      else if (pop && !push)
        lvl_q <= lvl_q - 9'h001;
      if (wr && a_data)
        rof_q <= 8'h00;
      else if (rd && a_data && ctrl_q.ring && !empty)
        rof_q <= rof_q + 8'h01;
      if (go)
        cnt_stk_q <= 1'b0;
      else if (samp_q >= scount_q && scount_q != 16'h0000)
        cnt_stk_q <= 1'b1;
      cnt_st_d1_q <= cnt_st;
    end
  end

  // ====================================================================
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_armed_trig;
    state_q == ST_ARM && ctrl_q.start_src == START_TRIG;
  endsequence
  sequence s_trig_fire;
    s_armed_trig ##0 (st_edge && i_clk_en && !abort && !err);
  endsequence

  chk_res_mask: assert property (push && !ctrl_q.res16 && i_clk_en
    |=> mem_q[$past(wp_q)] == {4'h0, $past(i_conv_data[11:0])})
    else $error("12-bit sample carries high bits");
  chk_diff_chan: assert property (o_conv_start && ctrl_q.diff |-> o_conv_ch < 4'h8)
    else $error("differential scan reached upper channel");
  chk_chan_order: assert property (done && !scan_end && !stop_met && !to_idle && i_clk_en
    |=> o_conv_start && o_conv_ch > $past(o_conv_ch))
    else $error("channel scan not ascending");
  chk_sw_start: assert property (go && state_q == ST_IDLE && ctrl_new.start_src == START_SW && i_clk_en
    |=> state_q == ST_RUN)
    else $error("software start did not run");
  chk_trig_start: assert property (s_trig_fire |=> state_q == ST_RUN)
    else $error("trigger edge did not start");
  chk_err_halt: assert property (err && i_clk_en |=> state_q == ST_IDLE ##1 !o_conv_start)
    else $error("error did not halt sampling");
  chk_ring_wrap: assert property (push && full && !to_idle && i_clk_en
    |=> lvl_q == LVL_FULL && rp_q == 8'($past(rp_q) + 8'h01) && o_busy)
    else $error("ring overwrite changed level");
  chk_fifo_count: assert property ($rose(cnt_st) && i_clk_en |=> ist_q[IRQ_CNT])
    else $error("count status missing");
  chk_sw_norep: assert property (stop_met && ctrl_q.start_src == START_SW && i_clk_en
    |=> state_q == ST_IDLE)
    else $error("software start repeated");
endmodule // aiss_top

// ===== verif/aiss_fe_model.sv
`timescale 1ns/1ps
// ========
// converter front end: answers each start three cycles later
// the top nibble carries the inverted channel so that 12-bit masking shows
module aiss_fe_model (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // conversion request
  input wire logic i_conv_start,
  input wire logic [3:0] i_conv_ch,
  // conversion result
  output logic o_conv_done,
  output logic [15:0] o_conv_data
);
  logic [1:0] wait_q;
  logic [3:0] ch_q;
  logic [7:0] seq_q;
  logic [15:0] last_q;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wait_q <= 2'h0;
      ch_q <= 4'h0;
      seq_q <= 8'h00;
      last_q <= 16'h0000;
      o_conv_done <= 1'b0;
    end
    else
    begin
      o_conv_done <= 1'b0;
      if (i_conv_start)
      begin
        wait_q <= 2'h2;
        ch_q <= i_conv_ch;
      end
      else if (wait_q != 2'h0)
      begin
        wait_q <= wait_q - 2'h1;
        if (wait_q == 2'h1)
        begin
          o_conv_done <= 1'b1;
          last_q <= {~ch_q, ch_q, seq_q};
          seq_q <= seq_q + 8'h01;
        end
      end
    end
  end

  // outside the done pulse the bus shows garbage, so stale data is never read as valid
  assign o_conv_data = o_conv_done ? last_q : ~last_q;
endmodule // aiss_fe_model

// ===== verif/aiss_top_tb.sv
`timescale 1ns/1ps
module aiss_top_tb;
  import aiss_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic conv_err = 1'b0;
  logic start_trig = 1'b0;
  logic stop_trig = 1'b0;
  logic ext_sclk = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_irq, o_busy, conv_start, conv_done;
  logic [3:0] conv_ch;
  logic [15:0] conv_data;
  logic [31:0] rd;
  logic se;
  int err_count = 0;
  int checked = 0;

  always #5 clk = ~clk;

  aiss_top aiss_top_i (.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_conv_start(conv_start), .o_conv_ch(conv_ch), .i_conv_done(conv_done),
    .i_conv_data(conv_data), .i_conv_err(conv_err), .i_ext_sclk(ext_sclk), .i_start_trig(start_trig),
    .i_stop_trig(stop_trig), .o_irq(o_irq), .o_busy(o_busy));

  aiss_fe_model aiss_fe_model_i (.i_clk_sys(clk), .i_sys_rst(rst), .i_conv_start(conv_start),
    .i_conv_ch(conv_ch), .o_conv_done(conv_done), .o_conv_data(conv_data));

  // ========
  // shared tasks
  task finish_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (o_pready !== 1'b1 && n < 20);
    if (n >= 20)
      chk(n, 0, "apb answer timed out");
    rd = o_prdata;
    se = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_idle(input int lim);
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    while (o_busy !== 1'b0 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk(o_busy, 0, "busy stuck");
  endtask

  task drain;
    int k;
    apb(0, REG_LEVEL, 0);
    k = rd[8:0];
    repeat (k) apb(0, REG_DATA, 0);
  endtask

  // ========
  // scenarios
  task t_reset;
    apb(0, REG_CHEN, 0);
    chk(rd, {16'h0, CHEN_RST}, "chen reset");
    apb(0, REG_SCOUNT, 0);
    chk(rd, {16'h0, SCOUNT_RST}, "scount reset");
    apb(0, REG_CLKDIV, 0);
    chk(rd, {16'h0, CLKDIV_RST}, "clkdiv reset");
    apb(0, REG_CTRL, 0);
    chk(rd, 0, "ctrl reset");
    apb(0, 8'hF0, 0);
    chk({31'h0, se}, 1, "unmapped slverr");
  endtask

  task t_fifo;
    logic [15:0] exp [4];
    exp = '{16'h0000, 16'h0201, 16'h0002, 16'h0203};
    apb(1, REG_CHEN, 32'h5);
    apb(1, REG_SCOUNT, 32'h2);
    apb(1, REG_REPEAT, 32'h3);
    apb(1, REG_CLKDIV, 32'h3F);
    apb(1, REG_IMASK, 32'h1 << IRQ_DONE);
    apb(1, REG_CTRL, 32'h1);
    wait_idle(2000);
    apb(0, REG_LEVEL, 0);
    chk(rd[8:0], 9'h4, "stored count");
    apb(0, REG_STATUS, 0);
    chk(rd[2], 1, "count reached");
    chk(o_irq, 1, "irq on done");
    for (int i = 0; i < 4; i++)
    begin
      apb(0, REG_DATA, 0);
      chk(rd, {16'h0, exp[i]}, "fifo order");
    end
    apb(0, REG_STATUS, 0);
    chk(rd[4:0], 5'h10, "drained status");
    apb(1, REG_ISTAT, 32'h7F);
    repeat (2) @(posedge clk);
    chk(o_irq, 0, "irq cleared");
  endtask

  task t_trig;
    apb(1, REG_REPEAT, 32'h1);
    apb(1, REG_CTRL, 32'h381);
    // a frozen block must not see a trigger pulse
    clk_en <= 1'b0;
    start_trig <= 1'b1;
    repeat (4) @(posedge clk);
    start_trig <= 1'b0;
    repeat (4) @(posedge clk);
    clk_en <= 1'b1;
    repeat (200) @(posedge clk);
    apb(0, REG_STATUS, 0);
    chk(rd[1:0], 2'h3, "waiting for edge");
    apb(0, REG_LEVEL, 0);
    chk(rd[8:0], 0, "nothing stored while waiting");
    start_trig <= 1'b1;
    repeat (4) @(posedge clk);
    start_trig <= 1'b0;
    repeat (300) @(posedge clk);
    apb(0, REG_STATUS, 0);
    chk(rd[1:0], 2'h1, "running after edge");
    apb(0, REG_LEVEL, 0);
    chk(rd[8:0] != 9'h0, 1, "stored after edge");
    apb(1, REG_CTRL, 32'h2);
    wait_idle(100);
    drain;
  endtask

  task t_err;
    apb(1, REG_CTRL, 32'h301);
    repeat (100) @(posedge clk);
    conv_err <= 1'b1;
    @(posedge clk);
    conv_err <= 1'b0;
    wait_idle(50);
    apb(0, REG_ISTAT, 0);
    chk(rd[IRQ_CERR], 1, "conversion error event");
    apb(1, REG_ISTAT, 32'h7F);
    drain;
  endtask

  task t_cmp;
    apb(1, REG_CHEN, 32'h105);
    apb(1, REG_CLKDIV, 32'hF);
    apb(1, REG_STCMP, 32'hF081);
    apb(1, REG_CTRL, 32'h1059);
    wait_idle(3000);
    apb(0, REG_ISTAT, 0);
    chk(rd[IRQ_START], 1, "compare start event");
    apb(0, REG_LEVEL, 0);
    chk(rd[8:0], 9'h3, "lower channels only after crossing");
    apb(0, REG_DATA, 0);
    chk(rd[31:1], {16'h0000, 8'hD2, 7'h41}, "first sample after crossing");
    apb(1, REG_ISTAT, 32'h7F);
    drain;
  endtask

  task t_ext;
    apb(1, REG_CTRL, 32'hA21);
    repeat (3)
    begin
      ext_sclk <= 1'b1;
      repeat (4) @(posedge clk);
      ext_sclk <= 1'b0;
      repeat (20) @(posedge clk);
    end
    apb(0, REG_LEVEL, 0);
    chk(rd[8:0], 9'h9, "one scan per external edge");
    stop_trig <= 1'b1;
    repeat (8) @(posedge clk);
    chk(o_busy, 1, "rising edge ignored for falling stop");
    stop_trig <= 1'b0;
    wait_idle(50);
    drain;
  endtask

  task t_ovf;
    apb(1, REG_CHEN, 32'hFFFF);
    apb(1, REG_CLKDIV, 32'hFF);
    apb(1, REG_CTRL, 32'h301);
    wait_idle(6000);
    apb(0, REG_ISTAT, 0);
    chk(rd[IRQ_OVF], 1, "fifo overflow event");
    apb(0, REG_LEVEL, 0);
    chk(rd[8:0], LVL_FULL, "fifo full level");
    apb(1, REG_ISTAT, 32'h7F);
    // ring mode on a full buffer must keep converting
    apb(1, REG_CTRL, 32'h305);
    repeat (4500) @(posedge clk);
    chk(o_busy, 1, "ring keeps running");
    apb(0, REG_ISTAT, 0);
    chk(rd[IRQ_OVF], 1, "ring overwrite event");
    apb(1, REG_CTRL, 32'h2);
    wait_idle(100);
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_fifo;
    t_trig;
    t_err;
    t_cmp;
    t_ext;
    t_ovf;
    finish_test;
  end

  // the whole run needs well under this many cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    finish_test;
  end
endmodule // aiss_top_tb
